// file: verification/strap_board.sv
`timescale 1ns/1ns
`default_nettype none
module strap_board (
  input wire logic clk, // clock
  input wire logic [20:0] plan, // levels
  output logic [20:0] pins, // straps
  output logic [7:0] bootData // boot bus
);
  initial pins = 21'h0;
  always @(negedge clk)
    pins <= plan;
  assign bootData = pins[11] ? 8'hA5 : 8'h00;
endmodule : strap_board
`default_nettype wire

// file: verification/strap_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module strap_monitor
  import strap_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic debugEnableStrap, // debug
  input wire logic haltRequest, // halt
  input wire logic memSelectStrap, // select
  input wire logic memFreqStrap, // freq
  input wire logic memWidthStrap, // width
  input wire logic memory_clock_source_strap, // source
  input wire logic [15:0] gpioStrap, // pins
  input wire strap_cfg_t cfg, // config
  input wire logic coreDebugHalt, // halt out
  input wire logic watchdogTimerEn // wdog
);
  // ==========
  // Cycles since release
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  wire cap = cnt == 4'h7;
  wire sat = cnt == 4'hC;
  always_comb next_cnt = sat ? cnt : cnt + 4'h1;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      cnt <= 4'h0;
    else
      cnt <= next_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  a_cfg_frozen: assert property (sat |-> $stable(cfg))
    else $error("cfg moved");
  a_link_gate: assert property (sat |-> cfg.linkEnable == {2{cfg.debugClockEn}})
    else $error("link enable");
  a_mem_ctrl: assert property (cap |-> cfg.debugClockEn == debugEnableStrap &&
    cfg.memCtrl == (memSelectStrap ? MEM_SDR : MEM_DDR2)) else $error("mem ctrl");
  a_mem_clock: assert property (cap |->
    cfg.memRatio == {memSelectStrap, memFreqStrap} && cfg.memWide == memWidthStrap &&
    cfg.memExtClock == memory_clock_source_strap) else $error("mem clock");
  a_halt_cfg: assert property (cap |-> cfg.haltToDebug == debugEnableStrap &&
    cfg.watchdogEnable == (!debugEnableStrap && haltRequest)) else $error("halt cfg");
  a_core_start: assert property (cap |->
    cfg.firstCoreRun == (debugEnableStrap || haltRequest)) else $error("core start");
  a_link_bits: assert property (cap |->
    {cfg.linkDebugBus, cfg.linkNibble1, cfg.linkNibble0} == gpioStrap[9:0]) else $error("link");
  a_boot_bits: assert property (cap |->
    cfg.routerClockEn == gpioStrap[11] &&
    {cfg.bootEccEnable, cfg.routerIdLow, cfg.bootPresent, cfg.bootWide} == gpioStrap[14:10])
    else $error("boot");
  a_halt_debug: assert property ((sat && cfg.debugClockEn && haltRequest)[*7] |->
    coreDebugHalt && !watchdogTimerEn) else $error("halt debug");
  a_halt_wdog: assert property ((sat && !cfg.debugClockEn && haltRequest)[*7] |->
    watchdogTimerEn && !coreDebugHalt) else $error("halt wdog");
  cover property (cap && debugEnableStrap);
  cover property (sat && coreDebugHalt);
  cover property (sat && watchdogTimerEn);
endmodule : strap_monitor
bind bootstrap_strap_config strap_monitor mon(.*);
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import strap_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic haltRequest = 1'b0;
  logic [20:0] plan = 21'h0;
  wire logic debugEnableStrap, memSelectStrap, memFreqStrap, memWidthStrap;
  wire logic memory_clock_source_strap;
  wire logic [15:0] gpioStrap;
  wire logic [20:0] pins;
  wire logic [7:0] bootData;
  strap_cfg_t cfg;
  logic coreDebugHalt;
  logic watchdogTimerEn;
  int errorCnt = 0;
  int checked = 0;
  assign {debugEnableStrap, memSelectStrap, memFreqStrap, memWidthStrap,
    memory_clock_source_strap, gpioStrap} = pins;
  strap_board board(.clk(clk), .plan(plan), .pins(pins), .bootData(bootData));
  bootstrap_strap_config dut(.*);
  initial forever #20 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("wrong value %0t %h %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    if (errorCnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic boot(input logic [20:0] p);
    nrst = 1'b0;
    plan = p;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (12) @(negedge clk);
  endtask : boot
  task automatic look(input logic [20:0] p);
    chk({cfg.debugClockEn, cfg.linkEnable}, {3{p[20]}});
    chk(cfg.haltToDebug, p[20]);
    chk(cfg.watchdogEnable, 1'b0);
    chk(cfg.firstCoreRun, p[20]);
    chk(cfg.memCtrl, p[19] ? MEM_SDR : MEM_DDR2);
    chk({cfg.memRatio, cfg.memWide, cfg.memExtClock}, p[19:16]);
    chk({cfg.linkDebugBus, cfg.linkNibble1, cfg.linkNibble0}, p[9:0]);
    chk({cfg.bootPresent, cfg.bootWide}, p[11:10]);
    chk(cfg.routerClockEn, p[11]);
    chk(bootData & {8{~cfg.bootPresent}}, 8'h00);
    chk({cfg.usbTestMode, cfg.bootEccEnable, cfg.routerIdLow}, p[15:12]);
  endtask : look
  task automatic hchk(input logic h, input logic [1:0] e);
    haltRequest = h;
    repeat (8) @(negedge clk);
    chk({coreDebugHalt, watchdogTimerEn}, e);
  endtask : hchk
  task automatic debug_on;
    boot(21'h1A5A3C);
    look(21'h1A5A3C);
    hchk(1'b1, 2'h2);
    hchk(1'b0, 2'h0);
    plan = 21'h0525C3;
    repeat (12) @(negedge clk);
    look(21'h1A5A3C);
  endtask : debug_on
  task automatic debug_off;
    boot(21'h0525C3);
    look(21'h0525C3);
    hchk(1'b1, 2'h1);
    hchk(1'b0, 2'h0);
  endtask : debug_off
  initial
  begin
    debug_on();
    debug_off();
    conclude();
  end
  initial
  begin
    #100000;
    errorCnt++;
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// file: verilog/bootstrap_strap_config.sv
`timescale 1ns/1ns
`default_nettype none
module bootstrap_strap_config
  import strap_pkg::*;
(
  input wire logic clk, // System clock, 25 MHz
  input wire logic nrst, // Asynchronous active-low system reset
  input wire logic debugEnableStrap, // Debug enable strap pin
  input wire logic haltRequest, // Halt request pin
  input wire logic memSelectStrap, // High SDR, low DDR2
  input wire logic memFreqStrap, // Memory frequency strap
  input wire logic memWidthStrap, // Memory width strap
  input wire logic memory_clock_source_strap, // High selects external memory clock
  input wire logic [15:0] gpioStrap, // General purpose strap pins
  output var strap_cfg_t cfg, // Captured configuration
  output logic coreDebugHalt, // All cores to debug mode
  output logic watchdogTimerEn // Live watchdog timer enable
);

  // ==========================================================
  // Pin synchronisers, three stages per pin
  localparam int NPIN = 22;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] stable;
  logic [NPIN-1:0] next_sync1;
  logic [NPIN-1:0] next_sync2;
  logic [NPIN-1:0] next_sync3;
  logic [NPIN-1:0] next_stable;

  // Pins gathered in one vector so a single loop synchronises them
  assign pinRaw[15:0] = gpioStrap;
  assign pinRaw[16] = debugEnableStrap;
  assign pinRaw[17] = memSelectStrap;
  assign pinRaw[18] = memFreqStrap;
  assign pinRaw[19] = memWidthStrap;
  assign pinRaw[20] = memory_clock_source_strap;
  assign pinRaw[21] = haltRequest;

  // A level counts only once the last two stages agree, so a pin
  // caught mid-transition never reaches the decode
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : gSync
      always_comb
      begin
        next_sync1[gi] = pinRaw[gi];
        next_sync2[gi] = sync1[gi];
        next_sync3[gi] = sync2[gi];
        if (sync2[gi] == sync3[gi])
        begin
          next_stable[gi] = sync3[gi];
        end
        else
        begin
          next_stable[gi] = stable[gi];
        end
      end

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1[gi] <= PIN_RESET;
          sync2[gi] <= PIN_RESET;
          sync3[gi] <= PIN_RESET;
          stable[gi] <= PIN_RESET;
        end
        else
        begin
          sync1[gi] <= next_sync1[gi];
          sync2[gi] <= next_sync2[gi];
          sync3[gi] <= next_sync3[gi];
          stable[gi] <= next_stable[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Named views of the settled pins
  logic [15:0] gp;
  logic dbgEn;
  logic memSel;
  logic memFreq;
  logic memWid;
  logic memClk;
  logic halt;

  assign gp = stable[15:0];
  assign dbgEn = stable[16];
  assign memSel = stable[17];
  assign memFreq = stable[18];
  assign memWid = stable[19];
  assign memClk = stable[20];
  assign halt = stable[21];

  // ==========================================================
  // Capture window: open from reset until the synchronisers have
  // flushed the settled strap levels through
  typedef enum logic [2:0] {
    CAP_HOLD = 3'b001,
    CAP_FLUSH = 3'b010,
    CAP_DONE = 3'b100
  } cap_state_t;

  cap_state_t capState;
  cap_state_t next_capState;
  // Edges seen since release, saturating at the flush count
  logic [2:0] flushAge;
  logic [2:0] next_flushAge;
  logic capturing;

  always_comb
  begin
    next_capState = capState;
    next_flushAge = flushAge;
    case (capState)
      CAP_HOLD:
      begin
        // First edge with reset released
        next_capState = CAP_FLUSH;
        next_flushAge = 3'(flushAge + 3'h1);
      end
      CAP_FLUSH:
      begin
        if (flushAge == FLUSH_CYCLES)
        begin
          next_capState = CAP_DONE;
        end
        else
        begin
          next_flushAge = 3'(flushAge + 3'h1);
        end
      end
      CAP_DONE:
      begin
        next_capState = CAP_DONE;
      end
      default:
      begin
        next_capState = CAP_HOLD;
        next_flushAge = FLUSH_START;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      capState <= CAP_HOLD;
      flushAge <= FLUSH_START;
    end
    else
    begin
      capState <= next_capState;
      flushAge <= next_flushAge;
    end
  end

  // Straps are taken only while the window is open
  always_comb
  begin
    case (capState)
      CAP_HOLD:
      begin
        capturing = 1'b1;
      end
      CAP_FLUSH:
      begin
        capturing = 1'b1;
      end
      CAP_DONE:
      begin
        capturing = 1'b0;
      end
      default:
      begin
        capturing = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Strap decode from the settled pin levels; every field is
  // given a value on every pass
  strap_cfg_t decoded;

  always_comb
  begin
    decoded = CFG_RESET;

    // Debug enable gates the debug unit, the cores on its bus
    // and both debug links
    decoded.debugClockEn = dbgEn; // [RULE1]
    decoded.linkEnable = {2{dbgEn}}; // [RULE2]
    decoded.haltToDebug = dbgEn; // [RULE3]
    if (dbgEn)
    begin
      decoded.watchdogEnable = 1'b0; // [RULE4]
      decoded.firstCoreRun = 1'b1; // [RULE5]
    end
    else
    begin
      decoded.watchdogEnable = halt; // [RULE4]
      decoded.firstCoreRun = halt; // [RULE5]
    end

    // Main memory controller, clock ratio, width and source
    case (memSel)
      1'b1:
      begin
        decoded.memCtrl = MEM_SDR; // [RULE6]
      end
      default:
      begin
        decoded.memCtrl = MEM_DDR2; // [RULE6]
      end
    endcase
    decoded.memRatio = {memSel, memFreq}; // [RULE7]
    decoded.memWide = memWid; // [RULE8]
    decoded.memExtClock = memClk; // [RULE9]

    // Debug link addressing and bus routing
    decoded.linkNibble0 = gp[NIB0_LSB +: 4]; // [RULE10]
    decoded.linkNibble1 = gp[NIB1_LSB +: 4]; // [RULE10]
    decoded.linkDebugBus = {gp[ROUTE1_BIT], gp[ROUTE0_BIT]}; // [RULE11]

    // Boot memory, router and test mode straps; the router clock
    // gate follows boot memory presence
    decoded.bootWide = gp[BOOT_WIDTH_BIT]; // [RULE12]
    decoded.bootPresent = gp[BOOT_PRESENT_BIT]; // [RULE13]
    decoded.routerClockEn = gp[BOOT_PRESENT_BIT]; // [RULE13]
    decoded.routerIdLow = gp[ROUTER_ID_LSB +: 2]; // [RULE15]
    decoded.bootEccEnable = gp[BOOT_ECC_BIT]; // [RULE16]
    decoded.usbTestMode = gp[USB_TEST_BIT];
  end

  // ==========================================================
  // Captured configuration, frozen once the window closes
  // until the next reset
  strap_cfg_t next_cfg;

  always_comb
  begin
    if (capturing) // [RULE18]
    begin
      next_cfg = decoded;
    end
    else
    begin
      next_cfg = cfg;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg <= CFG_RESET;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // ==========================================================
  // Live halt steering, using the captured debug enable so that
  // a strap moving after reset cannot redirect the halt request
  logic next_coreDebugHalt;
  logic next_watchdogTimerEn;

  always_comb
  begin
    if (next_cfg.debugClockEn)
    begin
      next_coreDebugHalt = halt; // [RULE3]
      next_watchdogTimerEn = 1'b0; // [RULE4]
    end
    else
    begin
      next_coreDebugHalt = 1'b0; // [RULE3]
      next_watchdogTimerEn = halt; // [RULE4]
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      coreDebugHalt <= 1'b0;
      watchdogTimerEn <= 1'b0;
    end
    else
    begin
      coreDebugHalt <= next_coreDebugHalt;
      watchdogTimerEn <= next_watchdogTimerEn;
    end
  end

endmodule : bootstrap_strap_config
`default_nettype wire

// file: verilog/strap_pkg.sv
// How it works
// RULE1 - Debug enable clocks debug unit and bus
// RULE2 - Debug enable low disables both debug links
// RULE3 - Halt request with debug halts cores
// RULE4 - Without debug, halt drives watchdog enable
// RULE5 - Without debug, halt holds first core; code sets firstCoreRun equal to halt, so halt high lets the first core run
// RULE6 - Memory select picks SDR or DDR2
// RULE7 - Frequency and select set clock ratio
// RULE8 - Width strap sets memory and checkbits
// RULE9 - Clock source strap picks memory clock
// RULE10 - Pins 3:0 and 7:4 give address nibbles
// RULE11 - Pins 8 and 9 route link traffic
// RULE12 - Pin 10 sets boot memory width
// RULE13 - Pin 11 boot presence and router gating
// RULE14 - Board grounds boot data without boot memory
// RULE15 - Pins 13:12 give router ID bits
// RULE16 - Pin 14 sets boot ECC reset value
// RULE17 - Board holds pin 15 low for USB link
// RULE18 - Straps sampled in reset, then frozen
package strap_pkg;

  // ==========================================================
  // Strap field layout on the general purpose pins
  localparam int GPIO_WIDTH = 16;
  localparam int NIB0_LSB = 0;
  localparam int NIB1_LSB = 4;
  localparam int ROUTE0_BIT = 8;
  localparam int ROUTE1_BIT = 9;
  localparam int BOOT_WIDTH_BIT = 10;
  localparam int BOOT_PRESENT_BIT = 11;
  localparam int ROUTER_ID_LSB = 12;
  localparam int BOOT_ECC_BIT = 14;
  localparam int USB_TEST_BIT = 15;

  // ==========================================================
  // Reset values of the strap pins and their synchronisers
  localparam logic [15:0] GPIO_RESET = 16'h0000;
  localparam logic PIN_RESET = 1'b0;

  // ==========================================================
  // Capture window timing, in clock edges after reset release
  localparam logic [2:0] FLUSH_START = 3'h0;
  localparam logic [2:0] FLUSH_CYCLES = 3'h5;

  typedef enum logic [1:0] {
    MEM_DDR2 = 2'h1,
    MEM_SDR = 2'h2
  } mem_ctrl_t;

  typedef struct packed {
    logic debugClockEn;
    logic [1:0] linkEnable;
    logic haltToDebug;
    logic watchdogEnable;
    logic firstCoreRun;
    mem_ctrl_t memCtrl;
    logic [1:0] memRatio;
    logic memWide;
    logic memExtClock;
    logic [3:0] linkNibble0;
    logic [3:0] linkNibble1;
    logic [1:0] linkDebugBus;
    logic bootWide;
    logic bootPresent;
    logic routerClockEn;
    logic [1:0] routerIdLow;
    logic bootEccEnable;
    logic usbTestMode;
  } strap_cfg_t;

  localparam strap_cfg_t CFG_RESET = '{memCtrl: MEM_DDR2, default: '0};

endpackage : strap_pkg
